/* File: common/ceh_pkg.sv */
/*
 * Constants for the compute engine host interface: the processor's byte
 * window onto engine words, word addresses, field positions, reset values
 * and frame timing.
 * Assumes an 8-bit processor bus and a 32768 Hz time base tick from a pin.
 */
package ceh_pkg;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam logic [15:0] CEH_BASE_ADDR      = 16'h1000;
    localparam int          CEH_WORD_DEPTH     = 128;
    localparam logic [6:0]  CEH_WORD_CONFIG    = 7'h10;
    localparam logic [6:0]  CEH_WORD_SAG_THRESHOLD   = 7'h14;
    localparam logic [6:0]  CEH_WORD_HOST_WATT = 7'h45;
    localparam logic [6:0]  CEH_WORD_HOST_VAR  = 7'h46;
    localparam logic [6:0]  CEH_WORD_STATUS    = 7'h7a;

    // ------------------------------------------------------------------
    // reset values and configuration write mask
    // ------------------------------------------------------------------
    localparam logic [31:0] CEH_CONFIG_RESET   = 32'h0000_5020;
    localparam logic [31:0] CEH_CONFIG_MASK    = 32'h0000_ff6f;
    localparam logic [31:0] CEH_SAG_THRESHOLD_RESET  = 32'h0000_0000;
    localparam logic [31:0] CEH_HOST_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // configuration word fields
    // ------------------------------------------------------------------
    localparam int CEH_CFG_SAG_SAMPLE_COUNT_LSB = 8;
    localparam int CEH_CFG_SAG_SAMPLE_COUNT_MSB = 15;
    localparam int CEH_CFG_FREQ_SEL    = 6;
    localparam int CEH_CFG_EXTERNAL_PULSE_SOURCE   = 5;
    localparam int CEH_CFG_CURRENT_B_SHUNT_GAIN    = 3;
    localparam int CEH_CFG_CURRENT_A_SHUNT_GAIN    = 2;
    localparam int CEH_CFG_PULSE_FAST  = 1;
    localparam int CEH_CFG_PULSE_SLOW  = 0;

    // ------------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------------
    localparam int CEH_ST_F0    = 28;
    localparam int CEH_ST_SAG_B = 26;
    localparam int CEH_ST_SAG_A = 25;

    // ------------------------------------------------------------------
    // equation select codes and gains
    // ------------------------------------------------------------------
    localparam logic [1:0] CEH_EQU_TAMPER  = 2'h0;
    localparam logic [1:0] CEH_EQU_3WIRE   = 2'h1;
    localparam logic [1:0] CEH_EQU_2ELEM   = 2'h2;
    localparam int         CEH_SHUNT_SHIFT = 3;
    localparam int         CEH_FAST_SHIFT  = 4;
    localparam int         CEH_SLOW_SHIFT  = 6;
    localparam logic [3:0] CEH_GAIN_SHUNT  = 4'h8;
    localparam logic [3:0] CEH_GAIN_PLAIN  = 4'h1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         CEH_TIMEBASE_HZ  = 32768;
    localparam int         CEH_FRAME_SETTLE = 1;
    localparam int         CEH_FRAME_CONV   = 12;
    localparam logic [3:0] CEH_FRAME_TICKS  =
        4'(CEH_FRAME_SETTLE + CEH_FRAME_CONV);

endpackage

/* File: design/ceh_sag_detect.sv */
/*
 * Sag detector for one phase voltage.
 * Assumes one sample strobe per engine code pass, same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module ceh_sag_detect (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sample_strobe,
    input  wire logic [31:0] voltage,
    input  wire logic [31:0] threshold,
    input  wire logic [7:0]  sag_count,
    output logic             sag_flag
);

    logic [31:0] magnitude;
    logic [7:0]  below_reg;
    logic        below;
    logic        above;

    // saturating magnitude, so the most negative code stays large
    always_comb begin
        if (!voltage[31])
            magnitude = voltage;
        else if (voltage == 32'h8000_0000)
            magnitude = 32'h7fff_ffff;
        else
            magnitude = 32'(-voltage);
    end

    assign below = magnitude < threshold;
    assign above = magnitude > threshold;

    // ------------------------------------------------------------------
    // consecutive below-threshold count
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            below_reg <= 8'h00;
        else if (sample_strobe) begin
            if (!below)
                below_reg <= 8'h00;
            else if (below_reg != 8'hff)
                below_reg <= below_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // flag: sets on the count, clears only above threshold
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            sag_flag <= 1'b0;
        else if (sample_strobe) begin
            if (below && (below_reg + 8'h01 >= sag_count))
                sag_flag <= 1'b1;
            else if (above)
                sag_flag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: design/ceh_engine_if.sv */
/*
 * Host side of the metering compute engine: processor byte window onto
 * engine words, frame timing from the 32768 Hz time base, element mapping,
 * status word with sag and fundamental flags, pulse source selection.
 * Assumes setup values from I/O RAM arrive on the clk domain, samples and
 * sums from the engine datapath are stable around the busy pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module ceh_engine_if #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             timebase_tick,
    input  wire logic [15:0]      mpu_addr,
    input  wire logic [7:0]       mpu_wdata,
    input  wire logic             mpu_wr,
    input  wire logic             mpu_rd,
    output logic      [7:0]       mpu_rdata,
    input  wire logic             engine_enable,
    input  wire logic [1:0]       meter_equation_select,
    input  wire logic [CNT_W-1:0] pre_sample_count,
    input  wire logic [CNT_W-1:0] summation_cycle_count,
    input  wire logic [31:0]      voltage_a,
    input  wire logic [31:0]      voltage_b,
    input  wire logic [31:0]      current_a,
    input  wire logic [31:0]      current_b,
    input  wire logic [31:0]      element0_watt_sum,
    input  wire logic [31:0]      element1_watt_sum,
    input  wire logic [31:0]      element0_var_sum,
    input  wire logic [31:0]      element1_var_sum,
    input  wire logic [31:0]      element0_current_square_sum,
    input  wire logic [31:0]      element1_current_square_sum,
    output logic                  engine_busy,
    output logic                  accum_done,
    output logic      [31:0]      element0_product,
    output logic      [31:0]      element1_product,
    output logic      [31:0]      element0_current,
    output logic      [31:0]      element1_current,
    output logic      [31:0]      pulse_watt_input,
    output logic      [31:0]      pulse_var_input,
    output logic      [3:0]       meter_gain_factor
);

    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
        $error("ceh_engine_if: CNT_W must be 1 to 16");
    end

    // ------------------------------------------------------------------
    // time base synchroniser and frame counter
    // ------------------------------------------------------------------
    logic       tb_meta_reg;
    logic       tb_sync_reg;
    logic       tb_prev_reg;
    logic       tb_rise;
    logic [3:0] frame_reg;
    logic       frame_end;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tb_meta_reg <= 1'b0;
            tb_sync_reg <= 1'b0;
            tb_prev_reg <= 1'b0;
        end else begin
            tb_meta_reg <= timebase_tick;
            tb_sync_reg <= tb_meta_reg;
            tb_prev_reg <= tb_sync_reg;
        end
    end

    localparam logic [3:0] CEH_LAST_TICK = ceh_pkg::CEH_FRAME_TICKS - 4'h1;

    assign tb_rise   = tb_sync_reg & ~tb_prev_reg;
    assign frame_end = tb_rise && (frame_reg == CEH_LAST_TICK);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            frame_reg <= 4'h0;
        else if (!engine_enable)
            frame_reg <= 4'h0;
        else if (frame_end)
            frame_reg <= 4'h0;
        else if (tb_rise)
            frame_reg <= frame_reg + 4'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            engine_busy <= 1'b0;
        else
            engine_busy <= engine_enable && frame_end;
    end

    // ------------------------------------------------------------------
    // accumulation interval
    // ------------------------------------------------------------------
    logic [2*CNT_W-1:0] accum_len;
    logic [2*CNT_W-1:0] accum_reg;

    assign accum_len = pre_sample_count * summation_cycle_count;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accum_reg  <= '0;
            accum_done <= 1'b0;
        end else if (!engine_enable) begin
            accum_reg  <= '0;
            accum_done <= 1'b0;
        end else if (frame_end && accum_len != '0) begin
            if (accum_reg + 1'b1 >= accum_len) begin
                accum_reg  <= '0;
                accum_done <= 1'b1;
            end else begin
                accum_reg  <= accum_reg + 1'b1;
                accum_done <= 1'b0;
            end
        end else
            accum_done <= 1'b0;
    end

    // ------------------------------------------------------------------
    // processor byte window onto engine words
    // ------------------------------------------------------------------
    logic [31:0] config_reg;
    logic [31:0] sag_threshold_reg;
    logic [31:0] host_watt_reg;
    logic [31:0] host_var_reg;
    logic [31:0] status_reg;
    logic [15:0] rel_addr;
    logic        in_window;
    logic [6:0]  word_idx;
    logic [4:0]  lane_lsb;
    logic [31:0] lane_mask;
    logic [31:0] lane_data;
    logic [31:0] read_word;

    assign rel_addr  = mpu_addr - ceh_pkg::CEH_BASE_ADDR;
    assign in_window = (mpu_addr >= ceh_pkg::CEH_BASE_ADDR)
                    && (rel_addr < 16'(4 * ceh_pkg::CEH_WORD_DEPTH));
    assign word_idx  = rel_addr[8:2];
    assign lane_lsb  = 5'(8 * (3 - int'(rel_addr[1:0])));
    assign lane_mask = 32'h0000_00ff << lane_lsb;
    assign lane_data = {24'h00_0000, mpu_wdata} << lane_lsb;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] mask,
                                          input logic [31:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            config_reg <= ceh_pkg::CEH_CONFIG_RESET;
        else if (mpu_wr && in_window
                 && word_idx == ceh_pkg::CEH_WORD_CONFIG)
            config_reg <= merge(config_reg, lane_mask, lane_data)
                        & ceh_pkg::CEH_CONFIG_MASK;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            sag_threshold_reg <= ceh_pkg::CEH_SAG_THRESHOLD_RESET;
        else if (mpu_wr && in_window
                 && word_idx == ceh_pkg::CEH_WORD_SAG_THRESHOLD)
            sag_threshold_reg <= merge(sag_threshold_reg, lane_mask, lane_data);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            host_watt_reg <= ceh_pkg::CEH_HOST_RESET;
            host_var_reg  <= ceh_pkg::CEH_HOST_RESET;
        end else if (mpu_wr && in_window) begin
            if (word_idx == ceh_pkg::CEH_WORD_HOST_WATT)
                host_watt_reg <= merge(host_watt_reg, lane_mask, lane_data);
            if (word_idx == ceh_pkg::CEH_WORD_HOST_VAR)
                host_var_reg <= merge(host_var_reg, lane_mask, lane_data);
        end
    end

    // status writes fall through to nothing
    always_comb begin
        unique case (word_idx)
            ceh_pkg::CEH_WORD_CONFIG:    read_word = config_reg;
            ceh_pkg::CEH_WORD_SAG_THRESHOLD:   read_word = sag_threshold_reg;
            ceh_pkg::CEH_WORD_HOST_WATT: read_word = host_watt_reg;
            ceh_pkg::CEH_WORD_HOST_VAR:  read_word = host_var_reg;
            ceh_pkg::CEH_WORD_STATUS:    read_word = status_reg;
            default:                     read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            mpu_rdata <= 8'h00;
        else if (mpu_rd && in_window)
            mpu_rdata <= 8'(read_word >> lane_lsb);
        else if (mpu_rd)
            mpu_rdata <= 8'h00;
    end

    // ------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------
    logic [7:0] sag_count;
    logic       freq_sel;
    logic       external_pulse_source;
    logic       shunt_a;
    logic       shunt_b;
    logic       pulse_fast;
    logic       pulse_slow;

    assign sag_count  = config_reg[ceh_pkg::CEH_CFG_SAG_SAMPLE_COUNT_MSB:
                                   ceh_pkg::CEH_CFG_SAG_SAMPLE_COUNT_LSB];
    assign freq_sel   = config_reg[ceh_pkg::CEH_CFG_FREQ_SEL];
    assign external_pulse_source  = config_reg[ceh_pkg::CEH_CFG_EXTERNAL_PULSE_SOURCE];
    assign shunt_a    = config_reg[ceh_pkg::CEH_CFG_CURRENT_A_SHUNT_GAIN];
    assign shunt_b    = config_reg[ceh_pkg::CEH_CFG_CURRENT_B_SHUNT_GAIN];
    assign pulse_fast = config_reg[ceh_pkg::CEH_CFG_PULSE_FAST];
    assign pulse_slow = config_reg[ceh_pkg::CEH_CFG_PULSE_SLOW];

    // ------------------------------------------------------------------
    // element mapping
    // ------------------------------------------------------------------
    logic signed [31:0] cur_a;
    logic signed [31:0] cur_b;
    logic signed [32:0] cur_diff;
    logic signed [31:0] elem0_cur;
    logic signed [31:0] elem0_volt;
    logic signed [31:0] elem1_volt;
    logic signed [63:0] prod0;
    logic signed [63:0] prod1;
    logic               half_scale;

    assign cur_a = shunt_a ? (signed'(current_a) <<< ceh_pkg::CEH_SHUNT_SHIFT)
                           : signed'(current_a);
    assign cur_b = shunt_b ? (signed'(current_b) <<< ceh_pkg::CEH_SHUNT_SHIFT)
                           : signed'(current_b);
    assign cur_diff = 33'(cur_a) - 33'(cur_b);

    always_comb begin
        elem0_volt = signed'(voltage_a);
        elem1_volt = signed'(voltage_a);
        elem0_cur  = cur_a;
        half_scale = 1'b0;
        unique case (meter_equation_select)
            ceh_pkg::CEH_EQU_3WIRE: begin
                elem0_cur  = cur_diff[32:1];
                half_scale = 1'b1;
            end
            ceh_pkg::CEH_EQU_2ELEM: begin
                elem1_volt = signed'(voltage_b);
            end
            default: begin
            end
        endcase
    end

    assign prod0 = elem0_volt * elem0_cur;
    assign prod1 = elem1_volt * cur_b;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            element0_product <= 32'h0000_0000;
            element1_product <= 32'h0000_0000;
            element0_current <= 32'h0000_0000;
            element1_current <= 32'h0000_0000;
        end else if (frame_end) begin
            element0_product <= prod0[62:31];
            element1_product <= half_scale ? prod1[63:32] : prod1[62:31];
            element0_current <= half_scale ? 32'(cur_diff) : elem0_cur;
            element1_current <= cur_b;
        end
    end

    // ------------------------------------------------------------------
    // sag detection and fundamental square wave
    // ------------------------------------------------------------------
    logic sag_a;
    logic sag_b;
    logic f0_level;

    ceh_sag_detect u_sag_a (
        .clk           (clk),
        .rstn          (rstn),
        .sample_strobe (frame_end),
        .voltage       (voltage_a),
        .threshold     (sag_threshold_reg),
        .sag_count     (sag_count),
        .sag_flag      (sag_a)
    );

    ceh_sag_detect u_sag_b (
        .clk           (clk),
        .rstn          (rstn),
        .sample_strobe (frame_end),
        .voltage       (voltage_b),
        .threshold     (sag_threshold_reg),
        .sag_count     (sag_count),
        .sag_flag      (sag_b)
    );

    // sign of the chosen phase gives one edge pair per line cycle
    assign f0_level = freq_sel ? ~voltage_b[31] : ~voltage_a[31];

    // taken on the busy cycle, so this pass's sag flags are already in
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            status_reg <= 32'h0000_0000;
        else if (engine_busy) begin
            status_reg                        <= 32'h0000_0000;
            status_reg[ceh_pkg::CEH_ST_F0]    <= f0_level;
            status_reg[ceh_pkg::CEH_ST_SAG_B] <= sag_b;
            status_reg[ceh_pkg::CEH_ST_SAG_A] <= sag_a;
        end
    end

    // ------------------------------------------------------------------
    // pulse generator source and scaling
    // ------------------------------------------------------------------
    logic signed [31:0] watt_src;
    logic signed [31:0] var_src;
    logic signed [31:0] watt_scaled;
    logic signed [31:0] var_scaled;

    always_comb begin
        if (external_pulse_source) begin
            watt_src = signed'(host_watt_reg);
            var_src  = signed'(host_var_reg);
        end else if (meter_equation_select == ceh_pkg::CEH_EQU_TAMPER) begin
            if (signed'(element0_current_square_sum)
                > signed'(element1_current_square_sum)) begin
                watt_src = signed'(element0_watt_sum);
                var_src  = signed'(element0_var_sum);
            end else begin
                watt_src = signed'(element1_watt_sum);
                var_src  = signed'(element1_var_sum);
            end
        end else begin
            watt_src = signed'(element0_watt_sum + element1_watt_sum);
            var_src  = signed'(element0_var_sum + element1_var_sum);
        end
    end

    function automatic logic signed [31:0] scale(input logic signed [31:0] v,
                                                 input logic fast,
                                                 input logic slow);
        logic signed [31:0] t;
        t = fast ? (v <<< ceh_pkg::CEH_FAST_SHIFT) : v;
        scale = slow ? (t >>> ceh_pkg::CEH_SLOW_SHIFT) : t;
    endfunction

    assign watt_scaled = scale(watt_src, pulse_fast, pulse_slow);
    assign var_scaled  = scale(var_src, pulse_fast, pulse_slow);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_watt_input <= 32'h0000_0000;
            pulse_var_input  <= 32'h0000_0000;
        end else begin
            pulse_watt_input <= watt_scaled;
            pulse_var_input  <= var_scaled;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            meter_gain_factor <= ceh_pkg::CEH_GAIN_PLAIN;
        else
            meter_gain_factor <= (shunt_a || shunt_b)
                               ? ceh_pkg::CEH_GAIN_SHUNT
                               : ceh_pkg::CEH_GAIN_PLAIN;
    end

endmodule

`default_nettype wire

/* File: testbench/ceh_engine_if_monitor.sv */
/* Checker on host interface ports: window reads, busy, products.
   Assumes the default build of ceh_engine_if. */
`timescale 1ns/1ns
`default_nettype none
module ceh_engine_if_monitor (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [15:0] mpu_addr,
    input wire logic        mpu_rd,
    input wire logic [7:0]  mpu_rdata,
    input wire logic        engine_busy,
    input wire logic        accum_done,
    input wire logic [31:0] element0_product,
    input wire logic [3:0]  meter_gain_factor
);
    // ------
    // checks
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_BUSY_GAP: assert property (
        engine_busy |=> !engine_busy [*8]) else $error("busy too close");
    AST_ACC_GAP: assert property (
        accum_done |=> !accum_done [*8]) else $error("accum too close");
    AST_RD_HOLD: assert property (
        !$past(mpu_rd) |-> $stable(mpu_rdata)) else $error("rdata moved");
    AST_OUTSIDE: assert property (
        $past(mpu_rd) && $past(mpu_addr) < 16'h1000 |-> mpu_rdata == 8'h00)
        else $error("outside read not zero");
    AST_ST_LOW: assert property (
        $past(mpu_rd) && $past(mpu_addr) inside {[16'h11e9:16'h11eb]}
        |-> mpu_rdata == 8'h00) else $error("status low bits set");
    AST_ST_TOP: assert property (
        $past(mpu_rd) && $past(mpu_addr) == 16'h11e8
        |-> (mpu_rdata & 8'he9) == 8'h00) else $error("status top bits set");
    AST_CFG_RSV: assert property (
        $past(mpu_rd) && $past(mpu_addr) == 16'h1043
        |-> (mpu_rdata & 8'h90) == 8'h00) else $error("config unused set");
    AST_PROD: assert property (
        $changed(element0_product) |-> engine_busy) else $error("prod moved");
    AST_GAIN: assert property (
        meter_gain_factor inside {4'h1, 4'h8}) else $error("bad gain");
    C_BUSY: cover property (engine_busy);
    C_ACC: cover property (accum_done);
    C_ST: cover property ($past(mpu_rd) && $past(mpu_addr) == 16'h11e8);
endmodule
bind ceh_engine_if ceh_engine_if_monitor ceh_engine_if_monitor_i (.clk,
    .rstn, .mpu_addr, .mpu_rd, .mpu_rdata, .engine_busy, .accum_done,
    .element0_product, .meter_gain_factor);
`default_nettype wire

/* File: testbench/ceh_mpu_model.sv */
/* Processor model: byte access to engine words, setup before enable.
   Assumes the host interface clock. */
`timescale 1ns/1ns
`default_nettype none
module ceh_mpu_model (
    input  wire logic        clk,
    input  wire logic [7:0]  mpu_rdata,
    output logic      [15:0] mpu_addr,
    output logic      [7:0]  mpu_wdata,
    output logic             mpu_wr,
    output logic             mpu_rd,
    output logic             engine_enable
);
    // -----------
    // bus cycles
    // -----------
    initial {mpu_addr, mpu_wdata, mpu_wr, mpu_rd, engine_enable} = '0;
    task automatic wr_word(input logic [6:0] w, input logic [31:0] d);
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            mpu_addr <= 16'h1000 + {7'h0, w, 2'h0} + 16'(b);
            mpu_wdata <= d[31-8*b -: 8];
            mpu_wr <= 1'b1;
        end
        @(posedge clk);
        mpu_wr <= 1'b0;
        mpu_wdata <= ~d[7:0];
        @(posedge clk);
        #1;
    endtask
    task automatic rd_byte(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        mpu_addr <= a;
        mpu_rd <= 1'b1;
        @(posedge clk);
        mpu_rd <= 1'b0;
        #1 v = mpu_rdata;
    endtask
    task automatic rd_word(input logic [6:0] w, output logic [31:0] d);
        for (int b = 0; b < 4; b++)
            rd_byte(16'h1000 + {7'h0, w, 2'h0} + 16'(b), d[31-8*b -: 8]);
    endtask
    // threshold and config first, then engine_enable set
    task automatic start(input logic [31:0] thr, input logic [31:0] cfg);
        wr_word(7'h14, thr);
        wr_word(7'h10, cfg);
        engine_enable <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: testbench/ceh_engine_if_tb_top.sv */
/* Bench for ceh_engine_if: registers, element mapping, sag, pulses.
   Assumes ceh_mpu_model drives the byte window. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module ceh_engine_if_tb_top;
    logic clk = 1'b0, rstn = 1'b0, timebase_tick = 1'b0;
    logic [15:0] mpu_addr, pre_sample_count = 16'h1;
    logic [15:0] summation_cycle_count = 16'h2;
    logic [7:0] mpu_wdata, mpu_rdata;
    logic mpu_wr, mpu_rd, engine_enable, engine_busy, accum_done;
    logic [1:0] meter_equation_select = 2'h0;
    logic [31:0] voltage_a = 32'h4000_0000, voltage_b = 32'h2000_0000;
    logic [31:0] current_a = 32'h4000_0000, current_b = 32'h2000_0000;
    logic [31:0] element0_watt_sum = 32'h100, element1_watt_sum = 32'h200;
    logic [31:0] element0_var_sum = 32'h10, element1_var_sum = 32'h20;
    logic [31:0] element0_current_square_sum = 32'h5, d;
    logic [31:0] element1_current_square_sum = 32'h3, element0_product;
    logic [31:0] element1_product, element0_current, element1_current;
    logic [31:0] pulse_watt_input, pulse_var_input;
    logic [3:0] meter_gain_factor;
    int err_total = 0, compares = 0, cyc = 0, acc_n = 0;
    ceh_engine_if ceh_engine_if_i (.clk, .rstn, .timebase_tick, .mpu_addr,
        .mpu_wdata, .mpu_wr, .mpu_rd, .mpu_rdata, .engine_enable,
        .meter_equation_select, .pre_sample_count, .summation_cycle_count,
        .voltage_a, .voltage_b, .current_a, .current_b, .element0_watt_sum,
        .element1_watt_sum, .element0_var_sum, .element1_var_sum,
        .element0_current_square_sum, .element1_current_square_sum,
        .engine_busy, .accum_done, .element0_product, .element1_product,
        .element0_current, .element1_current, .pulse_watt_input,
        .pulse_var_input, .meter_gain_factor);
    ceh_mpu_model mpu (.clk, .mpu_rdata, .mpu_addr, .mpu_wdata, .mpu_wr,
        .mpu_rd, .engine_enable);
    always #2 clk = ~clk;
    always #16 timebase_tick = ~timebase_tick;
    always @(negedge clk) if (accum_done === 1'b1) acc_n++;
    always @(posedge clk) if (++cyc == 20000) begin
        err_total++;
        finish_test;
    end
    task automatic wait_busy(input int n);
        repeat (n) do @(posedge clk); while (engine_busy !== 1'b1);
        @(posedge clk);
        #1;
    endtask
    task automatic t_regs;
        mpu.rd_word(7'h10, d);
        `CHK("cfg", 32'h0000_5020, d)
        mpu.wr_word(7'h7a, 32'hffff_ffff);
        mpu.rd_word(7'h7a, d);
        `CHK("status", 32'h0, d)
        mpu.wr_word(7'h10, 32'hffff_ffff);
        mpu.rd_word(7'h10, d);
        `CHK("cfg", 32'h0000_ff6f, d)
        `CHK("gain", 4'h8, meter_gain_factor)
        mpu.rd_byte(16'h0fff, d[7:0]);
        $display("t_regs done");
    endtask
    task automatic t_eq;
        logic [31:0] e1[3] = '{32'h1000_0000, 32'h0800_0000, 32'h0800_0000};
        logic [31:0] ep[3] = '{32'h100, 32'h300, 32'h300};
        logic [31:0] e0[3] = '{32'h2000_0000, 32'h0800_0000, 32'h2000_0000};
        logic [31:0] c0[3] = '{32'h4000_0000, 32'h2000_0000, 32'h4000_0000};
        mpu.start(32'h1000_0000, 32'h0000_0200);
        for (int e = 0; e < 3; e++) begin
            meter_equation_select <= 2'(e);
            wait_busy(2);
            `CHK("elem1", e1[e], element1_product)
            `CHK("elem0", e0[e], element0_product)
            `CHK("cur0", c0[e], element0_current)
            `CHK("cur1", 32'h2000_0000, element1_current)
            `CHK("pulse", ep[e], pulse_watt_input)
        end
        `CHK("var", 32'h30, pulse_var_input)
        acc_n = 0;
        wait_busy(4);
        `CHK("accum", 2, acc_n)
        $display("t_eq done");
    endtask
    task automatic t_sag(input logic [31:0] va, vb, cfg, exp, input int n);
        voltage_a <= va;
        voltage_b <= vb;
        mpu.wr_word(7'h10, cfg);
        wait_busy(n);
        mpu.rd_word(7'h7a, d);
        `CHK("status", exp, d)
        $display("t_sag done");
    endtask
    task automatic t_pulse;
        mpu.wr_word(7'h45, 32'h1234_0000);
        mpu.wr_word(7'h10, 32'h0000_0220);
        `CHK("host", 32'h1234_0000, pulse_watt_input)
        element1_current_square_sum <= 32'h9;
        meter_equation_select <= 2'h0;
        mpu.wr_word(7'h10, 32'h0000_0202);
        `CHK("fast", 32'h2000, pulse_watt_input)
        mpu.wr_word(7'h10, 32'h0000_0201);
        `CHK("slow", 32'h8, pulse_watt_input)
        $display("t_pulse done");
    endtask
    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_eq;
        t_sag(32'h0800_0000, 32'h2000_0000, 32'h0200, 32'h1000_0000, 1);
        t_sag(32'h0800_0000, 32'h2000_0000, 32'h0200, 32'h1200_0000, 1);
        t_sag(32'hc000_0000, 32'h0800_0000, 32'h0240, 32'h1400_0000, 3);
        t_sag(32'hc000_0000, 32'h2000_0000, 32'h0200, 32'h0, 2);
        t_pulse;
        finish_test;
    end
endmodule
`default_nettype wire
